// *** include/ebi_pkg.sv ***
// Package of types and constants for the external memory bus interface
package ebi_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int ADDR_W   = 22;
    localparam int DATA_W   = 16;
    localparam int OPND_W   = 32;
    localparam int NUM_CS   = 6;
    localparam int CSIDX_W  = 3;
    localparam int WAIT_W   = 4;

    // ************************************************************
    // Operand sizes
    // ************************************************************
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // ************************************************************
    // Field positions and fixed values
    // ************************************************************
    localparam int IACK_LSB = 2;
    localparam int IACK_MSB = 4;
    localparam logic [WAIT_W-1:0] NOMATCH_WAIT = 4'h0;

    // ************************************************************
    // Bus sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_ACTIVE
    } ebi_state_t;

    // ************************************************************
    // Chip-select settings
    // ************************************************************
    typedef struct packed {
        logic                enable;
        logic [ADDR_W-1:0]   base;
        logic [ADDR_W-1:0]   mask;
        logic                port_byte;
        logic                burst_en;
        logic [WAIT_W-1:0]   wait_states;
        logic                ext_term;
        logic                byte_strobe_sel;
    } ebi_cs_cfg_t;

    localparam ebi_cs_cfg_t CS_CFG_RESET = '0;

    typedef struct packed {
        logic                valid;
        logic [CSIDX_W-1:0]  sel;
        ebi_cs_cfg_t         cfg;
    } ebi_cfg_wr_t;

    // ************************************************************
    // Access request and answer
    // ************************************************************
    typedef struct packed {
        logic                write;
        logic                iack;
        logic [2:0]          iack_level_bits;
        logic [1:0]          size;
        logic [ADDR_W-1:0]   addr;
        logic [OPND_W-1:0]   wdata;
    } ebi_req_t;

    typedef struct packed {
        logic                valid;
        logic [OPND_W-1:0]   rdata;
    } ebi_resp_t;

endpackage : ebi_pkg

// *** logic/ebi_bus_if.sv ***
// External memory bus sequencer with chip-selects, wait states and bursts
`timescale 1ns/1ps
// Summary of operation
// - Address driven at each subtransfer start and held while chip-select asserted, except between burst subtransfers.
// - Interrupt acknowledge puts acknowledged level on address bits 4:2.
// - Each cycle moves one or two bytes, sampled on rising edge.
// - Writes drive all sixteen data lines regardless of sizes.
// - Per chip-select base, mask, size, burst, waits, termination; reset disables.
// - Address transition start pulses low when a new address appears.
// - Read strobe asserted while ready to accept read data.
// - Direction output high for reads, low for writes.
// - Write-enable mode asserts byte enables on writes only.
// - Data-strobe mode asserts byte enables on reads and writes.
// - Word port writes enable upper and lower lanes carrying valid data.
// - Byte ports use upper lane only; address bit 0 picks byte.
// - Acknowledge ends externally terminated cycles; read data latched after sync.
// - Reset selects write-enable mode; mode bit selects data-strobe mode.
// - Programmed wait states of the accessed chip-select are inserted unless it uses external termination.
// - Burst only on internal reads wider than port with bursting enabled.
// - Burst keeps chip-select and read strobe asserted; only address and address transition start change.
// - Bursts honour wait states; acknowledge ends only externally terminated cycles, which never burst.
// - Every bus cycle takes at least two clocks.
// - Read data captured on last rising edge before chip-select negates.
// - Burst-inhibited access negates chip-select and strobes between subtransfers.

module ebi_bus_if (
    input  wire logic                               CLK,
    input  wire logic                               RESET_N,
    input  wire ebi_pkg::ebi_cfg_wr_t               CFG_WR,
    input  wire logic                               REQ_VALID,
    input  wire ebi_pkg::ebi_req_t                  REQ,
    output logic                                    REQ_READY,
    output ebi_pkg::ebi_resp_t                      RESP,
    output logic [ebi_pkg::ADDR_W-1:0]              ADDR_OUT,
    output logic [ebi_pkg::DATA_W-1:0]              DATA_OUT,
    output logic                                    DATA_OE,
    input  wire logic [ebi_pkg::DATA_W-1:0]         DATA_IN,
    output logic [ebi_pkg::NUM_CS-1:0]              CS_N,
    output logic                                    ADDR_TRANSITION_START_N,
    output logic                                    RD_STROBE_N,
    output logic                                    WR_DIR_N,
    output logic                                    UPPER_BYTE_EN_N,
    output logic                                    LOWER_BYTE_EN_N,
    input  wire logic                               XFER_ACK_N
);

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        ebi_pkg::ebi_state_t                        fsm;
        ebi_pkg::ebi_cs_cfg_t [ebi_pkg::NUM_CS-1:0] cfg;
        logic                                       hit;
        logic [ebi_pkg::CSIDX_W-1:0]                cs_idx;
        logic                                       write;
        logic [1:0]                                 size;
        logic [ebi_pkg::ADDR_W-1:0]                 addr;
        logic [ebi_pkg::OPND_W-1:0]                 wdata;
        logic [ebi_pkg::OPND_W-1:0]                 rdata;
        logic [1:0]                                 sub_cnt;
        logic [1:0]                                 sub_last;
        logic                                       port_byte;
        logic                                       burst;
        logic                                       ext_term;
        logic                                       strobe_mode;
        logic [ebi_pkg::WAIT_W-1:0]                 wait_ld;
        logic [ebi_pkg::WAIT_W-1:0]                 wait_cnt;
        logic                                       hold;
        logic                                       ack_s1;
        logic                                       ack_s2;
        logic                                       ack_s3;
        logic [ebi_pkg::ADDR_W-1:0]                 addr_o;
        logic [ebi_pkg::DATA_W-1:0]                 data_o;
        logic                                       data_oe;
        logic [ebi_pkg::NUM_CS-1:0]                 cs_n;
        logic                                       ats_n;
        logic                                       rd_n;
        logic                                       wr_dir_n;
        logic                                       ube_n;
        logic                                       lbe_n;
        logic                                       ready;
        ebi_pkg::ebi_resp_t                         resp;
    } ebi_regs_t;

    ebi_regs_t r_reg;
    ebi_regs_t r_next;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Lowest numbered enabled chip-select whose unmasked bits match
    function automatic logic [ebi_pkg::CSIDX_W:0] ebi_match(
        input ebi_pkg::ebi_cs_cfg_t [ebi_pkg::NUM_CS-1:0] cfg,
        input logic [ebi_pkg::ADDR_W-1:0]                 a
    );
        logic [ebi_pkg::CSIDX_W:0] res;
        res = '0;
        for (int i = ebi_pkg::NUM_CS - 1; i >= 0; i--) begin
            if (cfg[i].enable &&
                (((a ^ cfg[i].base) & ~cfg[i].mask) == '0)) begin
                res = {1'b1, i[ebi_pkg::CSIDX_W-1:0]};
            end
        end
        return res;
    endfunction : ebi_match

    // Number of operand bytes, size 3 treated as a long
    function automatic logic [2:0] ebi_nbytes(input logic [1:0] sz);
        logic [2:0] nb;
        case (sz)
            ebi_pkg::SZ_BYTE: nb = 3'h1;
            ebi_pkg::SZ_WORD: nb = 3'h2;
            default:          nb = 3'h4;
        endcase
        return nb;
    endfunction : ebi_nbytes

    // Bus lanes for subtransfer k, most significant part first
    function automatic logic [ebi_pkg::DATA_W-1:0] ebi_lane_data(
        input logic [ebi_pkg::OPND_W-1:0] wd,
        input logic [1:0]                 sz,
        input logic                       pb,
        input logic [1:0]                 k
    );
        logic [2:0]                nb;
        logic [4:0]                sh;
        logic [ebi_pkg::OPND_W-1:0] v;
        nb = ebi_nbytes(sz);
        sh = 5'h0;
        v  = '0;
        if (sz == ebi_pkg::SZ_BYTE) begin
            v = wd;
        end else if (pb) begin
            sh = 5'((nb - 3'h1 - {1'b0, k}) * 4'h8);
            v  = wd >> sh;
        end else begin
            sh = 5'(((nb >> 1) - 3'h1 - {1'b0, k}) * 5'h10);
            v  = wd >> sh;
        end
        if (sz == ebi_pkg::SZ_BYTE || pb) begin
            return {v[7:0], v[7:0]};
        end
        return v[15:0];
    endfunction : ebi_lane_data

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [ebi_pkg::CSIDX_W:0]    m;
        ebi_pkg::ebi_cs_cfg_t         c;
        logic [ebi_pkg::ADDR_W-1:0]   a;
        logic [2:0]                   nb;
        logic                         sub_end;
        logic                         active;
        logic                         be_on;
        logic [ebi_pkg::ADDR_W-1:0]   off;
        logic [ebi_pkg::OPND_W-1:0]   rd;
        m       = '0;
        c       = ebi_pkg::CS_CFG_RESET;
        a       = '0;
        nb      = 3'h0;
        sub_end = 1'b0;
        active  = 1'b0;
        be_on   = 1'b0;
        off     = '0;
        rd      = r_reg.rdata;
        r_next  = r_reg;

        r_next.resp.valid = 1'b0;

        // Acknowledge pin synchroniser plus one stage for edge detect
        r_next.ack_s1 = XFER_ACK_N;
        r_next.ack_s2 = r_reg.ack_s1;
        r_next.ack_s3 = r_reg.ack_s2;

        // Chip-select settings
        if (CFG_WR.valid &&
            CFG_WR.sel < ebi_pkg::CSIDX_W'(ebi_pkg::NUM_CS)) begin
            r_next.cfg[CFG_WR.sel] = CFG_WR.cfg;
        end

        // ********************************************************
        // Sequencer
        // ********************************************************
        case (r_reg.fsm)
            ebi_pkg::ST_IDLE: begin
                if (REQ_VALID && r_reg.ready) begin
                    a = REQ.addr;
                    if (REQ.iack) begin
                        a[ebi_pkg::IACK_MSB:ebi_pkg::IACK_LSB] =
                            REQ.iack_level_bits;
                    end
                    m = ebi_match(r_reg.cfg, a);
                    if (m[ebi_pkg::CSIDX_W]) begin
                        c = r_reg.cfg[m[ebi_pkg::CSIDX_W-1:0]];
                    end else begin
                        c = ebi_pkg::CS_CFG_RESET;
                        c.wait_states = ebi_pkg::NOMATCH_WAIT;
                    end
                    nb = ebi_nbytes(REQ.size);
                    r_next.hit         = m[ebi_pkg::CSIDX_W];
                    r_next.cs_idx      = m[ebi_pkg::CSIDX_W-1:0];
                    r_next.write       = REQ.write;
                    r_next.size        = REQ.size;
                    r_next.addr        = a;
                    r_next.wdata       = REQ.wdata;
                    r_next.rdata       = '0;
                    r_next.port_byte   = c.port_byte;
                    r_next.ext_term    = c.ext_term;
                    r_next.strobe_mode = c.byte_strobe_sel;
                    r_next.wait_ld     = c.wait_states;
                    r_next.wait_cnt    = c.wait_states;
                    r_next.sub_cnt     = 2'h0;
                    r_next.sub_last    = c.port_byte ? 2'(nb - 3'h1) :
                                         2'((nb >> 1) - 3'h1 + {2'h0,
                                         (REQ.size == ebi_pkg::SZ_BYTE)});
                    r_next.burst       = !REQ.write && !c.ext_term &&
                                         c.burst_en &&
                                         (nb > (c.port_byte ? 3'h1 : 3'h2));
                    r_next.hold        = 1'b0;
                    r_next.fsm         = ebi_pkg::ST_START;
                end
            end
            ebi_pkg::ST_START: begin
                // Address phase then strobe phase: two clocks at least
                r_next.fsm = ebi_pkg::ST_ACTIVE;
            end
            ebi_pkg::ST_ACTIVE: begin
                if (r_reg.ext_term) begin
                    if (!r_reg.ack_s2 && r_reg.ack_s3) begin
                        sub_end = 1'b1;
                    end
                end else if (r_reg.wait_cnt == '0) begin
                    sub_end = 1'b1;
                end else begin
                    r_next.wait_cnt = r_reg.wait_cnt - 1'b1;
                end
            end
            default: begin
                r_next.fsm = ebi_pkg::ST_IDLE;
            end
        endcase

        // ********************************************************
        // End of a subtransfer
        // ********************************************************
        if (sub_end) begin
            // Sampled while chip-select still low, the last such edge
            if (r_reg.port_byte) begin
                rd = {r_reg.rdata[23:0], DATA_IN[15:8]};
            end else if (r_reg.size == ebi_pkg::SZ_BYTE) begin
                rd = {r_reg.rdata[23:0], r_reg.addr_o[0] ?
                      DATA_IN[7:0] : DATA_IN[15:8]};
            end else begin
                rd = {r_reg.rdata[15:0], DATA_IN};
            end
            if (!r_reg.write) begin
                r_next.rdata = rd;
            end
            if (r_reg.sub_cnt == r_reg.sub_last) begin
                r_next.fsm        = ebi_pkg::ST_IDLE;
                r_next.resp.valid = 1'b1;
                r_next.resp.rdata = r_reg.write ? '0 : rd;
            end else begin
                r_next.sub_cnt  = r_reg.sub_cnt + 2'h1;
                r_next.wait_cnt = r_reg.wait_ld;
                r_next.hold     = r_reg.burst;
                r_next.fsm      = ebi_pkg::ST_START;
            end
        end

        // ********************************************************
        // Pin values from the next state
        // ********************************************************
        if (r_next.fsm == ebi_pkg::ST_START) begin
            off = r_next.port_byte ? ebi_pkg::ADDR_W'(r_next.sub_cnt) :
                  ebi_pkg::ADDR_W'({r_next.sub_cnt, 1'b0});
            r_next.addr_o = r_next.addr + off;
        end

        active = (r_next.fsm == ebi_pkg::ST_ACTIVE) ||
                 (r_next.fsm == ebi_pkg::ST_START && r_next.hold);

        r_next.ats_n = !(r_next.fsm == ebi_pkg::ST_START);

        r_next.cs_n = '1;
        if (active && r_next.hit) begin
            r_next.cs_n[r_next.cs_idx] = 1'b0;
        end

        r_next.rd_n = !(active && !r_next.write);

        r_next.wr_dir_n = !((r_next.fsm != ebi_pkg::ST_IDLE) &&
                            r_next.write);

        be_on = active && (r_next.write || r_next.strobe_mode);
        r_next.ube_n = 1'b1;
        r_next.lbe_n = 1'b1;
        if (be_on) begin
            if (r_next.port_byte) begin
                r_next.ube_n = 1'b0;
            end else if (r_next.size == ebi_pkg::SZ_BYTE) begin
                r_next.ube_n = r_next.addr_o[0];
                r_next.lbe_n = !r_next.addr_o[0];
            end else begin
                r_next.ube_n = 1'b0;
                r_next.lbe_n = 1'b0;
            end
        end

        // Writes drive the full bus for the whole cycle
        r_next.data_oe = (r_next.fsm != ebi_pkg::ST_IDLE) &&
                         r_next.write;
        if (r_next.fsm == ebi_pkg::ST_START && r_next.write) begin
            r_next.data_o = ebi_lane_data(r_next.wdata, r_next.size,
                                          r_next.port_byte,
                                          r_next.sub_cnt);
        end

        r_next.ready = (r_next.fsm == ebi_pkg::ST_IDLE);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            r_reg          <= '0;
            r_reg.fsm      <= ebi_pkg::ST_IDLE;
            r_reg.cfg      <= '{default: ebi_pkg::CS_CFG_RESET};
            r_reg.ack_s1   <= 1'b1;
            r_reg.ack_s2   <= 1'b1;
            r_reg.ack_s3   <= 1'b1;
            r_reg.cs_n     <= '1;
            r_reg.ats_n    <= 1'b1;
            r_reg.rd_n     <= 1'b1;
            r_reg.wr_dir_n <= 1'b1;
            r_reg.ube_n    <= 1'b1;
            r_reg.lbe_n    <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign REQ_READY               = r_reg.ready;
    assign RESP                    = r_reg.resp;
    assign ADDR_OUT                = r_reg.addr_o;
    assign DATA_OUT                = r_reg.data_o;
    assign DATA_OE                 = r_reg.data_oe;
    assign CS_N                    = r_reg.cs_n;
    assign ADDR_TRANSITION_START_N = r_reg.ats_n;
    assign RD_STROBE_N             = r_reg.rd_n;
    assign WR_DIR_N                = r_reg.wr_dir_n;
    assign UPPER_BYTE_EN_N         = r_reg.ube_n;
    assign LOWER_BYTE_EN_N         = r_reg.lbe_n;

endmodule : ebi_bus_if

// *** test/ebi_mem_model.sv ***
// Behavioural memory device on the far side of the bus
`timescale 1ns/1ps
module ebi_mem_model #(
    parameter int         ACK_CS  = 3,
    parameter logic [3:0] ACK_DLY = 4'h2
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] data_out,
    input  wire logic [5:0]  cs_n,
    input  wire logic        rd_strobe_n,
    input  wire logic        wr_dir_n,
    input  wire logic        up_n,
    input  wire logic        lo_n,
    output logic [15:0]      data_in,
    output logic             ack_n,
    output logic [15:0]      wr_data,
    output logic [1:0]       wr_be,
    output logic [1:0]       rd_be
);
    logic [15:0] last = 16'h0000;
    logic [3:0]  cnt;
    logic        sel;
    assign sel = cs_n != 6'h3F;
    // Byte value tracks address; released bus toggles
    assign data_in = rd_strobe_n ? ~last : {addr[7:0], ~addr[7:0]};
    always_ff @(posedge clk) begin
        last <= data_in;
        if (!rst_n) begin
            ack_n <= 1'b1;
            cnt   <= 4'h0;
            rd_be <= 2'h3;
        end else begin
            cnt   <= cs_n[ACK_CS] ? 4'h0 : cnt + 4'h1;
            ack_n <= !(!cs_n[ACK_CS] && cnt == ACK_DLY);
            if (sel && !rd_strobe_n) rd_be <= {up_n, lo_n};
            if (sel && !wr_dir_n && !(up_n && lo_n)) begin
                wr_data <= data_out;
                wr_be   <= {up_n, lo_n};
            end
        end
    end
endmodule : ebi_mem_model

// *** test/ebi_bus_if_props.sv ***
// Timing relations checked on the bus interface ports
`timescale 1ns/1ps
module ebi_bus_if_props (
    input wire logic                       CLK,
    input wire logic                       RESET_N,
    input wire logic                       REQ_VALID,
    input wire logic                       REQ_READY,
    input wire ebi_pkg::ebi_resp_t         RESP,
    input wire logic [ebi_pkg::ADDR_W-1:0] ADDR_OUT,
    input wire logic                       DATA_OE,
    input wire logic [ebi_pkg::NUM_CS-1:0] CS_N,
    input wire logic                       ADDR_TRANSITION_START_N,
    input wire logic                       RD_STROBE_N,
    input wire logic                       WR_DIR_N,
    input wire logic                       UPPER_BYTE_EN_N,
    input wire logic                       XFER_ACK_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic sel;
    assign sel = CS_N != '1;
    property p_addr_hold;
        sel && $past(sel) && !WR_DIR_N |-> $stable(ADDR_OUT);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_ats_pulse;
        $fell(ADDR_TRANSITION_START_N) |=> ADDR_TRANSITION_START_N;
    endproperty
    a_ats_pulse: assert property (p_ats_pulse) else $error("start too long");
    property p_ats_addr;
        $changed(ADDR_OUT) |-> !ADDR_TRANSITION_START_N;
    endproperty
    a_ats_addr: assert property (p_ats_addr) else $error("no start mark");
    property p_rd_dir;
        !RD_STROBE_N |-> WR_DIR_N && !DATA_OE;
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("read direction");
    property p_wr_drive;
        sel && !WR_DIR_N |-> DATA_OE;
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write undriven");
    property p_min_cycle;
        REQ_VALID && REQ_READY |=> !RESP.valid [*2];
    endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("cycle too short");
    property p_reset_cs;
        $rose(RESET_N) |-> CS_N == '1;
    endproperty
    a_reset_cs: assert property (p_reset_cs) else $error("select after reset");
    property p_ack_end;
        $fell(XFER_ACK_N) && sel |-> ##[1:5] !sel;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack ignored");
    property p_be_read;
        WR_DIR_N && !UPPER_BYTE_EN_N |-> !RD_STROBE_N;
    endproperty
    a_be_read: assert property (p_be_read) else $error("stray strobe");
    c_ext: cover property (!XFER_ACK_N && sel);
    c_read: cover property (!RD_STROBE_N ##1 RD_STROBE_N);
    c_resp: cover property (RESP.valid);
endmodule : ebi_bus_if_props
bind ebi_bus_if ebi_bus_if_props u_props (.CLK, .RESET_N, .REQ_VALID,
    .REQ_READY, .RESP, .ADDR_OUT, .DATA_OE, .CS_N, .ADDR_TRANSITION_START_N,
    .RD_STROBE_N, .WR_DIR_N, .UPPER_BYTE_EN_N, .XFER_ACK_N);

// *** test/ebi_bus_if_test.sv ***
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module ebi_bus_if_test;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic REQ_VALID = 1'b0;
    ebi_pkg::ebi_cfg_wr_t CFG_WR = '0;
    ebi_pkg::ebi_req_t REQ = '0;
    ebi_pkg::ebi_resp_t RESP;
    logic REQ_READY, DATA_OE, ATS_N, RD_N, WR_N, UP_N, LO_N, ACK_N;
    logic [21:0] ADDR_OUT, seen_addr;
    logic [15:0] DATA_OUT, DATA_IN, wr_data;
    logic [5:0] CS_N, cs_and;
    logic [1:0] wr_be, rd_be;
    logic [31:0] rd;
    int n, ncs, error_cnt = 0, check_count = 0;
    always #5 CLK = ~CLK;
    ebi_bus_if dut (.CLK, .RESET_N, .CFG_WR, .REQ_VALID, .REQ, .REQ_READY,
        .RESP, .ADDR_OUT, .DATA_OUT, .DATA_OE, .DATA_IN, .CS_N,
        .ADDR_TRANSITION_START_N(ATS_N), .RD_STROBE_N(RD_N), .WR_DIR_N(WR_N),
        .UPPER_BYTE_EN_N(UP_N), .LOWER_BYTE_EN_N(LO_N), .XFER_ACK_N(ACK_N));
    ebi_mem_model u_mem (.clk(CLK), .rst_n(RESET_N), .addr(ADDR_OUT),
        .data_out(DATA_OUT), .cs_n(CS_N), .rd_strobe_n(RD_N), .wr_dir_n(WR_N),
        .up_n(UP_N), .lo_n(LO_N), .data_in(DATA_IN), .ack_n(ACK_N),
        .wr_data(wr_data), .wr_be(wr_be), .rd_be(rd_be));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_cyc(input int got, input int exp);
        chk_val(32'(got), 32'(exp));
    endtask : chk_cyc
    task automatic cfg(input logic [2:0] s, input logic [21:0] b,
        input logic pb, input logic bu, input logic [3:0] w, input logic x,
        input logic ds);
        @(posedge CLK);
        CFG_WR <= '{1'b1, s, '{1'b1, b, 22'h0000FF, pb, bu, w, x, ds}};
    endtask : cfg
    task automatic xfer(input logic w, input logic ik, input logic [1:0] sz,
        input logic [21:0] a, input logic [31:0] wd);
        @(posedge CLK);
        REQ <= '{w, ik, 3'h5, sz, a, wd};
        REQ_VALID <= 1'b1;
        do @(negedge CLK); while (REQ_READY !== 1'b1);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        n = 0;
        ncs = 0;
        cs_and = 6'h3F;
        do begin
            @(negedge CLK);
            if (n == 0) seen_addr = ADDR_OUT;
            cs_and &= CS_N;
            if (CS_N != 6'h3F) ncs++;
            n++;
        end while (RESP.valid !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        rd = RESP.rdata;
    endtask : xfer
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        @(negedge CLK);
        chk_val(32'(CS_N), 32'h3F);
        cfg(3'h0, 22'h000000, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
        cfg(3'h1, 22'h000100, 1'b1, 1'b0, 4'h1, 1'b0, 1'b0);
        cfg(3'h2, 22'h000200, 1'b1, 1'b1, 4'h1, 1'b0, 1'b0);
        cfg(3'h3, 22'h000300, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1);
        @(posedge CLK);
        CFG_WR.valid <= 1'b0;
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h000010, 32'h0);
        chk_val(rd, 32'h000010EF);
        chk_cyc(n, 3);
        chk_val(32'(cs_and), 32'h3E);
        chk_val(32'(rd_be), 32'h3);
        xfer(1'b0, 1'b1, ebi_pkg::SZ_WORD, 22'h000010, 32'h0);
        chk_val(32'(seen_addr[4:2]), 32'h5);
        xfer(1'b1, 1'b0, ebi_pkg::SZ_WORD, 22'h000014, 32'h0000BEEF);
        chk_val(32'(wr_data), 32'hBEEF);
        chk_val(32'(wr_be), 32'h0);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 1'b0, ebi_pkg::SZ_BYTE, 22'(32'h12 + i), 32'h5A);
            chk_val(32'(wr_be), 32'(i + 1));
        end
        xfer(1'b0, 1'b0, ebi_pkg::SZ_LONG, 22'h000040, 32'h0);
        chk_val(rd, 32'h40BF42BD);
        chk_cyc(n, 5);
        chk_cyc(ncs, 2);
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h000120, 32'h0);
        chk_val(rd, 32'h00002021);
        chk_cyc(n, 7);
        chk_cyc(ncs, 4);
        chk_val(32'(cs_and), 32'h3D);
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h000220, 32'h0);
        chk_val(rd, 32'h00002021);
        chk_cyc(n, 7);
        chk_cyc(ncs, 5);
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h000310, 32'h0);
        chk_val(rd, 32'h000010EF);
        chk_val(32'(rd_be), 32'h0);
        chk_cyc(n, 8);
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h003000, 32'h0);
        chk_val(32'(cs_and), 32'h3F);
        chk_cyc(n, 3);
        // Mid-run reset must clear the chip-select 3 setting
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RESET_N <= 1'b1;
        xfer(1'b0, 1'b0, ebi_pkg::SZ_WORD, 22'h000310, 32'h0);
        chk_val(32'(cs_and), 32'h3F);
        chk_cyc(n, 3);
        report_and_stop();
    end
    initial begin
        #50us;
        error_cnt++;
        report_and_stop();
    end
endmodule : ebi_bus_if_test
